// >>> common/mtx_pkg.sv
/*
  Shared constants and types for the mask-test / exclusive-OR / nibble-exchange / wait execution block.
  Assumes an 8-bit core whose decoder hands over opcode and fetched operand values.
*/
package mtx_pkg;

  // Operand and flag widths
  localparam int MTX_DATA_W = 8;

  // Flag bit positions inside the flags byte
  localparam int FLAG_C_POS = 7;
  localparam int FLAG_Z_POS = 6;
  localparam int FLAG_S_POS = 5;
  localparam int FLAG_V_POS = 4;
  localparam int FLAG_D_POS = 3;
  localparam int FLAG_H_POS = 2;

  // Opcodes, nibble exchange
  localparam logic [7:0] OPC_SWAP_R = 8'hF0;
  localparam logic [7:0] OPC_SWAP_IR = 8'hF1;
  // Opcodes, complement-mask test
  localparam logic [7:0] OPC_TCMASK_RR = 8'h62;
  localparam logic [7:0] OPC_TCMASK_RIR = 8'h63;
  localparam logic [7:0] OPC_TCMASK_LO = 8'h64;
  localparam logic [7:0] OPC_TCMASK_HI = 8'h66;
  // Opcodes, mask test
  localparam logic [7:0] OPC_TMASK_RR = 8'h72;
  localparam logic [7:0] OPC_TMASK_RIR = 8'h73;
  localparam logic [7:0] OPC_TMASK_LO = 8'h74;
  localparam logic [7:0] OPC_TMASK_HI = 8'h76;
  // Opcodes, exclusive OR
  localparam logic [7:0] OPC_XOR_RR = 8'hB2;
  localparam logic [7:0] OPC_XOR_RIR = 8'hB3;
  localparam logic [7:0] OPC_XOR_LO = 8'hB4;
  localparam logic [7:0] OPC_XOR_HI = 8'hB6;
  // Opcode, wait for interrupt
  localparam logic [7:0] OPC_WAIT_IRQ = 8'h3F;

  // Cycle counts
  localparam int CYC_SHORT = 4;
  localparam int CYC_LONG = 6;
  localparam int CYC_WAIT_UNIT = 4;
  localparam int MTX_CNT_W = 3;

  // Reset values
  localparam logic [7:0] MTX_BYTE_RST = 8'h00;

  // Kinds of operation handled here
  typedef enum logic [2:0] {
    op_none,
    op_swap,
    op_test_complement_under_mask,
    op_test_under_mask,
    op_xor,
    op_wait_for_interrupt_op
  } mtx_kind_type;

endpackage : mtx_pkg

// >>> src/mtx_alu.sv
/*
  Combinational result and flag logic for the executed operation.
  Assumes operands and incoming flags are held stable by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module mtx_alu
  import mtx_pkg::*;
#(
  parameter int DATA_W = MTX_DATA_W
)
(
  input wire mtx_kind_type kind,
  input wire logic [DATA_W-1:0] dst,
  input wire logic [DATA_W-1:0] src,
  input wire logic [7:0] flags_in,
  output logic [DATA_W-1:0] result,
  output logic [7:0] flags_new,
  output logic write_dst
);

  // Result, write-back and flag update per kind
  always_comb
  begin
    result = dst;
    write_dst = 1'b0;
    flags_new = flags_in;
    case (kind)
      op_swap:
      begin
        result = {dst[3:0], dst[7:4]};
        write_dst = 1'b1;
      end
      op_test_complement_under_mask: result = ~dst & src;
      op_test_under_mask: result = dst & src;
      op_xor:
      begin
        result = dst ^ src;
        write_dst = 1'b1;
      end
      default: result = dst;
    endcase
    if (kind == op_swap || kind == op_test_complement_under_mask || kind == op_test_under_mask || kind == op_xor)
    begin
      flags_new[FLAG_Z_POS] = (result == '0);
      flags_new[FLAG_S_POS] = result[DATA_W-1];
    end
    // Carry and overflow left as they were for the exchange
    if (kind == op_test_complement_under_mask || kind == op_test_under_mask || kind == op_xor)
    begin
      flags_new[FLAG_V_POS] = 1'b0;
    end
  end

endmodule : mtx_alu
`default_nettype wire

// >>> src/mtx_cycle_timer.sv
/*
  Down counter that times instruction cycles; reports when it has reached zero.
  Assumes load takes priority over counting.
*/
`timescale 1ns/1ps
`default_nettype none
module mtx_cycle_timer
  import mtx_pkg::*;
#(
  parameter int CNT_W = MTX_CNT_W
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic at_zero
);

  logic [CNT_W-1:0] cnt_q;

  // Load or count down, holding at zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (load)
      cnt_q <= load_val;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  assign at_zero = (cnt_q == '0);

endmodule : mtx_cycle_timer
`default_nettype wire

// >>> src/mtx_exec.sv
/*
  Execution unit for nibble exchange, complement-mask test, mask test, exclusive OR and wait for interrupt.
  Assumes the decoder supplies fetched operand values and the register file accepts one write per completion.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Opcode F1 exchanges the two nibbles of the indirectly addressed register in 4 cycles.
// - The exchange sets Z on a zero result and S from bit 7, keeps D and H, and F0 is its direct form.
// - The complement-mask test ANDs the inverted destination with the mask and writes no operand.
// - The complement-mask test clears V and keeps C, D and H.
// - The complement-mask test decodes 62 and 63 in 4 and 6 cycles and 64 to 66 in 6 cycles.
// - The mask test ANDs destination with mask and writes no operand.
// - The mask test decodes 72 and 73 in 4 and 6 cycles and 74 to 76 in 6 cycles.
// - Both tests and exclusive OR set Z on a zero 8-bit result and copy bit 7 to S.
// - The mask test and exclusive OR clear V and keep C, D and H.
// - Exclusive OR writes destination XOR source back, B2 in 4 cycles and B3 to B6 in 6 cycles.
// - Opcode 3F waits in whole multiples of 4 cycles until an interrupt and touches no flag.
// - While waiting, DMA may run and an internal or fast interrupt ends the wait.
module mtx_exec
  import mtx_pkg::*;
#(
  parameter int DATA_W = MTX_DATA_W
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [7:0] op_code,
  input wire logic [DATA_W-1:0] dst_val,
  input wire logic [DATA_W-1:0] src_val,
  input wire logic [7:0] flags_in,
  input wire logic irq_internal,
  input wire logic irq_fast,
  output logic busy,
  output logic waiting,
  output logic dma_allow,
  output logic done,
  output logic illegal_op,
  output logic dst_we,
  output logic [DATA_W-1:0] dst_data,
  output logic flags_we,
  output logic [7:0] flags_out
);

  localparam logic [MTX_CNT_W-1:0] LOAD_SHORT = MTX_CNT_W'(CYC_SHORT - 1);
  localparam logic [MTX_CNT_W-1:0] LOAD_LONG = MTX_CNT_W'(CYC_LONG - 1);
  localparam logic [MTX_CNT_W-1:0] LOAD_WAIT = MTX_CNT_W'(CYC_WAIT_UNIT - 1);

  typedef enum logic [1:0] {
    st_idle,
    st_exec,
    st_wait
  } mtx_state_type;

  mtx_state_type state_q;
  mtx_kind_type kind_q;
  mtx_kind_type dec_kind;
  logic [MTX_CNT_W-1:0] dec_load;
  logic [DATA_W-1:0] dst_q;
  logic [DATA_W-1:0] src_q;
  logic [7:0] flg_q;
  logic [DATA_W-1:0] alu_res;
  logic [7:0] alu_flags;
  logic alu_wr;
  logic accept;
  logic t_zero;
  logic t_load;
  logic wake_q;
  logic wake_now;
  logic finish;
  logic done_q;
  logic illegal_q;
  logic dst_we_q;
  logic [DATA_W-1:0] dst_data_q;
  logic flags_we_q;
  logic [7:0] flags_out_q;
  mtx_kind_type done_kind_q;

  // Opcode decode into kind and cycle budget
  always_comb
  begin
    dec_kind = op_none;
    dec_load = LOAD_LONG;
    case (op_code)
      OPC_SWAP_R, OPC_SWAP_IR:
      begin
        dec_kind = op_swap;
        dec_load = LOAD_SHORT;
      end
      OPC_TCMASK_RR:
      begin
        dec_kind = op_test_complement_under_mask;
        dec_load = LOAD_SHORT;
      end
      OPC_TMASK_RR:
      begin
        dec_kind = op_test_under_mask;
        dec_load = LOAD_SHORT;
      end
      OPC_XOR_RR:
      begin
        dec_kind = op_xor;
        dec_load = LOAD_SHORT;
      end
      OPC_WAIT_IRQ:
      begin
        dec_kind = op_wait_for_interrupt_op;
        dec_load = LOAD_WAIT;
      end
      default:
      begin
        if (op_code == OPC_TCMASK_RIR || (op_code >= OPC_TCMASK_LO && op_code <= OPC_TCMASK_HI))
          dec_kind = op_test_complement_under_mask;
        else if (op_code == OPC_TMASK_RIR || (op_code >= OPC_TMASK_LO && op_code <= OPC_TMASK_HI))
          dec_kind = op_test_under_mask;
        else if (op_code == OPC_XOR_RIR || (op_code >= OPC_XOR_LO && op_code <= OPC_XOR_HI))
          dec_kind = op_xor;
        else
          dec_kind = op_none;
      end
    endcase
  end

  // Handshake and status
  assign op_ready = (state_q == st_idle);
  assign accept = op_valid && op_ready;
  assign busy = (state_q != st_idle);
  assign waiting = (state_q == st_wait);
  assign dma_allow = (state_q == st_wait);
  assign wake_now = wake_q || irq_internal || irq_fast;
  assign finish = t_zero && ((state_q == st_exec) || (state_q == st_wait && wake_now));

  // Timer reload at start and at each empty 4-cycle quantum
  assign t_load = (accept && dec_kind != op_none) || (state_q == st_wait && t_zero && !wake_now);
  mtx_cycle_timer #(
    .CNT_W(MTX_CNT_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(t_load),
    .load_val(accept ? dec_load : LOAD_WAIT),
    .at_zero(t_zero)
  );

  mtx_alu #(
    .DATA_W(DATA_W)
  ) u_alu (
    .kind(kind_q),
    .dst(dst_q),
    .src(src_q),
    .flags_in(flg_q),
    .result(alu_res),
    .flags_new(alu_flags),
    .write_dst(alu_wr)
  );

  // Sequencer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state_q <= st_idle;
    else
      case (state_q)
        st_idle:
          if (accept && dec_kind == op_wait_for_interrupt_op)
            state_q <= st_wait;
          else if (accept && dec_kind != op_none)
            state_q <= st_exec;
        st_exec:
          if (t_zero)
            state_q <= st_idle;
        st_wait:
          if (t_zero && wake_now)
            state_q <= st_idle;
        default: state_q <= st_idle;
      endcase
  end

  // Operand capture on accept
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      kind_q <= op_none;
      dst_q <= '0;
      src_q <= '0;
      flg_q <= MTX_BYTE_RST;
    end
    else if (accept)
    begin
      kind_q <= dec_kind;
      dst_q <= dst_val;
      src_q <= src_val;
      flg_q <= flags_in;
    end
  end

  // Interrupt seen during the wait; set beats clear, and a new instruction drops any leftover
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      wake_q <= 1'b0;
    else if (state_q == st_wait && (irq_internal || irq_fast))
      wake_q <= 1'b1;
    else if (finish || accept)
      wake_q <= 1'b0;
  end

  // Commit of write-back and flags in one cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      done_q <= 1'b0;
      dst_we_q <= 1'b0;
      flags_we_q <= 1'b0;
      dst_data_q <= '0;
      flags_out_q <= MTX_BYTE_RST;
      done_kind_q <= op_none;
    end
    else
    begin
      done_q <= finish;
      dst_we_q <= finish && alu_wr;
      flags_we_q <= finish && (kind_q != op_wait_for_interrupt_op);
      if (finish)
      begin
        dst_data_q <= alu_res;
        flags_out_q <= alu_flags;
        done_kind_q <= kind_q;
      end
    end
  end

  // Unknown opcode report
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      illegal_q <= 1'b0;
    else
      illegal_q <= accept && (dec_kind == op_none);
  end

  assign done = done_q;
  assign illegal_op = illegal_q;
  assign dst_we = dst_we_q;
  assign dst_data = dst_data_q;
  assign flags_we = flags_we_q;
  assign flags_out = flags_out_q;

  // Helper logic for the checks below
  logic [15:0] wait_len_q;
  logic [DATA_W-1:0] chk_dst_q;
  logic [DATA_W-1:0] chk_src_q;
  logic [7:0] chk_flg_q;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      wait_len_q <= '0;
    else if (accept)
      wait_len_q <= '0;
    else if (state_q == st_wait)
      wait_len_q <= wait_len_q + 16'h0001;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      chk_dst_q <= '0;
      chk_src_q <= '0;
      chk_flg_q <= MTX_BYTE_RST;
    end
    else if (finish)
    begin
      chk_dst_q <= dst_q;
      chk_src_q <= src_q;
      chk_flg_q <= flg_q;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_short_run;
    busy [*4] ##1 (done && !busy);
  endsequence
  sequence s_long_run;
    busy [*6] ##1 (done && !busy);
  endsequence

  a_short_cycle_count: assert property (
    accept && (op_code == OPC_SWAP_IR || op_code == OPC_TCMASK_RR || op_code == OPC_TMASK_RR || op_code == OPC_XOR_RR)
    |=> s_short_run)
    else $error("short-form instruction did not take 4 cycles");

  a_long_cycle_count: assert property (
    accept && (op_code == OPC_TCMASK_RIR || op_code == OPC_TMASK_RIR || op_code == OPC_XOR_RIR
    || (op_code >= OPC_TCMASK_LO && op_code <= OPC_TCMASK_HI)
    || (op_code >= OPC_TMASK_LO && op_code <= OPC_TMASK_HI)
    || (op_code >= OPC_XOR_LO && op_code <= OPC_XOR_HI))
    |=> s_long_run)
    else $error("long-form instruction did not take 6 cycles");

  a_swap_result: assert property (
    done && done_kind_q == op_swap |-> dst_we && dst_data == {chk_dst_q[3:0], chk_dst_q[7:4]})
    else $error("nibble exchange result wrong");

  a_xor_result: assert property (
    done && done_kind_q == op_xor |-> dst_we && dst_data == (chk_dst_q ^ chk_src_q))
    else $error("exclusive OR write-back wrong");

  a_test_no_write: assert property (
    done && (done_kind_q == op_test_complement_under_mask || done_kind_q == op_test_under_mask)
    |-> !dst_we && flags_we)
    else $error("mask test wrote an operand");

  a_zero_sign_flags: assert property (
    done && done_kind_q == op_test_under_mask
    |-> flags_out[FLAG_Z_POS] == ~|(chk_dst_q & chk_src_q) && flags_out[FLAG_S_POS] == (chk_dst_q[7] & chk_src_q[7]))
    else $error("mask test Z or S wrong");

  a_compl_zero_flag: assert property (
    done && done_kind_q == op_test_complement_under_mask
    |-> flags_out[FLAG_Z_POS] == ((~chk_dst_q & chk_src_q) == '0) && !flags_out[FLAG_V_POS])
    else $error("complement-mask test Z or V wrong");

  a_keep_cdh_flags: assert property (
    flags_we |-> flags_out[FLAG_C_POS] == chk_flg_q[FLAG_C_POS] && flags_out[FLAG_D_POS] == chk_flg_q[FLAG_D_POS]
    && flags_out[FLAG_H_POS] == chk_flg_q[FLAG_H_POS])
    else $error("C, D or H changed");

  a_wait_quantum: assert property (
    done && done_kind_q == op_wait_for_interrupt_op |-> wait_len_q[1:0] == 2'b00 && wait_len_q != '0
    && !flags_we && !dst_we)
    else $error("wait did not last a multiple of 4 cycles or touched flags");

  a_wait_wakeup: assert property (
    waiting && (irq_internal || irq_fast) |-> dma_allow ##[1:4] done)
    else $error("interrupt did not end the wait in time");

  a_commit_together: assert property (
    dst_we |-> done && flags_we && $past(busy))
    else $error("write-back not committed with flags");

endmodule : mtx_exec
`default_nettype wire

// >>> bench/tb.sv
/*
  Self-checking bench for the mtx_exec execution block.
  Assumes 20 MHz sys_clk and synchronous active-low reset; expectations come from the package constants.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mtx_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic [7:0] op_code = 8'h00;
  logic [7:0] dst_val = 8'h00;
  logic [7:0] src_val = 8'h00;
  logic [7:0] flags_in = 8'h00;
  logic irq_internal = 1'b0;
  logic irq_fast = 1'b0;
  logic op_ready, busy, waiting, dma_allow, done, illegal_op, dst_we, flags_we;
  logic [7:0] dst_data, flags_out;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc_cnt = 0;

  mtx_exec i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .dst_val(dst_val), .src_val(src_val), .flags_in(flags_in),
    .irq_internal(irq_internal), .irq_fast(irq_fast), .busy(busy), .waiting(waiting),
    .dma_allow(dma_allow), .done(done), .illegal_op(illegal_op), .dst_we(dst_we),
    .dst_data(dst_data), .flags_we(flags_we), .flags_out(flags_out)
  );

  // Clock, 50 ns period
  always #25 sys_clk = ~sys_clk;

  task end_sim;
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 2000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Count cycles after an accept edge until done shows
  task automatic wait_done(output int n);
    for (n = 1; n < 40; n++)
    begin
      @(negedge sys_clk);
      if (done === 1'b1)
        break;
    end
  endtask : wait_done

  // One instruction; irq pulses land in cycle ic / fc after accept
  task automatic run_op(input logic [7:0] op, d, s, f, input int ic, fc, exp_n);
    logic [7:0] res;
    logic [7:0] ef;
    logic we;
    int n;
    we = 1'b1;
    ef = f;
    res = d ^ s;
    if (op == OPC_SWAP_R || op == OPC_SWAP_IR)
      res = {d[3:0], d[7:4]};
    else if (op inside {[OPC_TCMASK_RR:OPC_TCMASK_HI]})
    begin
      res = ~d & s;
      we = 1'b0;
    end
    else if (op inside {[OPC_TMASK_RR:OPC_TMASK_HI]})
    begin
      res = d & s;
      we = 1'b0;
    end
    if (op == OPC_WAIT_IRQ)
      we = 1'b0;
    if (op != OPC_SWAP_R && op != OPC_SWAP_IR)
      ef[FLAG_V_POS] = 1'b0;
    ef[FLAG_Z_POS] = (res == 8'h00);
    ef[FLAG_S_POS] = res[7];
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= op;
    dst_val <= d;
    src_val <= s;
    flags_in <= f;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    irq_internal <= (ic == 1);
    irq_fast <= (fc == 1);
    for (n = 1; n < 40; n++)
    begin
      @(negedge sys_clk);
      if (done === 1'b1)
        break;
      if (n == 1)
        check("busy", {7'h00, busy}, 8'h01);
      if (op == OPC_WAIT_IRQ)
        check("waiting", {6'h00, waiting, dma_allow}, 8'h03);
      @(posedge sys_clk);
      irq_internal <= (n + 1 == ic);
      irq_fast <= (n + 1 == fc);
    end
    check("latency", n[7:0], exp_n[7:0]);
    check("dst_we", {7'h00, dst_we}, {7'h00, we});
    check("flags_we", {7'h00, flags_we}, {7'h00, op != OPC_WAIT_IRQ});
    if (we)
      check("dst_data", dst_data, res);
    if (op != OPC_WAIT_IRQ)
      check("flags_out", flags_out, ef);
    @(posedge sys_clk);
    irq_internal <= 1'b0;
    irq_fast <= 1'b0;
  endtask : run_op

  // Outputs while reset is held
  task t_reset;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check("ready_busy", {6'h00, op_ready, busy}, 8'h02);
    check("wait_dma", {6'h00, waiting, dma_allow}, 8'h00);
    check("pulses", {4'h0, done, illegal_op, dst_we, flags_we}, 8'h00);
    check("rst dst_data", dst_data, 8'h00);
    check("rst flags_out", flags_out, 8'h00);
    @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : t_reset

  // Nibble exchange, both forms
  task t_swap;
    run_op(OPC_SWAP_IR, 8'hA4, 8'h00, 8'hFF, 0, 0, 5);
    run_op(OPC_SWAP_R, 8'h3E, 8'h00, 8'h00, 0, 0, 5);
    run_op(OPC_SWAP_IR, 8'h00, 8'hFF, 8'h9C, 0, 0, 5);
  endtask : t_swap

  // Every opcode of both tests and exclusive OR
  task t_table;
    logic [7:0] d;
    logic [7:0] s;
    logic [7:0] f;
    for (int i = 0; i < 5; i++)
    begin
      d = i[0] ? 8'h2B : 8'hC7;
      s = i[1] ? 8'h23 : 8'h02;
      f = i[0] ? 8'hDC : 8'h2F;
      run_op(OPC_TCMASK_RR + i[7:0], d, s, f, 0, 0, (i == 0) ? 5 : 7);
      run_op(OPC_TMASK_RR + i[7:0], d, s, f, 0, 0, (i == 0) ? 5 : 7);
      run_op(OPC_XOR_RR + i[7:0], d, s, f, 0, 0, (i == 0) ? 5 : 7);
    end
    run_op(OPC_XOR_RR, 8'h5A, 8'h5A, 8'hFF, 0, 0, 5);
    run_op(OPC_TMASK_HI, 8'h2B, 8'h54, 8'hFF, 0, 0, 7);
  endtask : t_table

  // Wait lengths in whole quanta, both interrupt kinds
  task t_wait;
    run_op(OPC_WAIT_IRQ, 8'h00, 8'h00, 8'h00, 6, 0, 9);
    run_op(OPC_WAIT_IRQ, 8'h00, 8'h00, 8'h00, 0, 3, 5);
    run_op(OPC_WAIT_IRQ, 8'h00, 8'h00, 8'h00, 4, 0, 5);
    run_op(OPC_WAIT_IRQ, 8'h00, 8'h00, 8'h00, 5, 0, 9);
    run_op(OPC_WAIT_IRQ, 8'h00, 8'h00, 8'h00, 0, 13, 17);
  endtask : t_wait

  // Opcode in the gap between two decoded groups
  task t_illegal;
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= 8'h67;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    @(negedge sys_clk);
    check("illegal", {6'h00, illegal_op, busy}, 8'h02);
    repeat (8)
    begin
      @(negedge sys_clk);
      check("no done", {7'h00, done}, 8'h00);
    end
  endtask : t_illegal

  // Request held during busy, taken in the done cycle
  task t_b2b;
    int n;
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= OPC_XOR_RR;
    dst_val <= 8'hC7;
    src_val <= 8'h02;
    flags_in <= 8'h00;
    @(posedge sys_clk);
    op_code <= OPC_TMASK_HI;
    dst_val <= 8'h2B;
    src_val <= 8'h54;
    wait_done(n);
    check("first latency", n[7:0], 8'h05);
    check("first result", dst_data, 8'hC5);
    @(posedge sys_clk);
    op_valid <= 1'b0;
    wait_done(n);
    check("second latency", n[7:0], 8'h07);
    check("second flags", flags_out, 8'h40);
  endtask : t_b2b

  // Main sequence
  initial
  begin
    t_reset();
    t_swap();
    t_table();
    t_wait();
    t_illegal();
    t_b2b();
    end_sim();
  end
endmodule : tb
`default_nettype wire
